// ---- sim/ucm_far_model.sv ----
module ucm_far_model #(
	parameter logic [63:0] DIE_ID_VALUE = 64'h1122_3344_5566_7788 // arbitrary neutral value
) (
	input  wire logic        core_clk,
	output logic             baud_clk_in,
	output logic      [63:0] die_id
);
	timeunit 1ns;
	timeprecision 1ps;
	logic half_cnt;

	// the die identifier is a fixed level, present from power-up
	assign die_id = DIE_ID_VALUE;

	// baud clock: two core cycles a half period, moved on the falling edge so it never races sampling
	initial begin
		half_cnt = 1'b0;
		baud_clk_in = 1'b0;
		forever begin
			@(negedge core_clk);
			half_cnt <= ~half_cnt;
			if (half_cnt) begin
				baud_clk_in <= ~baud_clk_in;
			end
		end
	end
endmodule

// ---- sim/ucm_regs_tb.sv ----
module ucm_regs_tb import ucm_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [15:0] a; logic [7:0] d; logic [7:0] e;} ucm_row_t;
	localparam logic [63:0] DIE = 64'hC3A5_5A3C_0F1E_2D4B; // arbitrary value
	logic core_clk, rst_b, reg_wr_en, reg_rd_en, bus_reset_signal, baud_clk_in, prev;
	logic core_reset_b, pullup_pin, remote_wake_pulse, infrared_select, transfer_dir, setup_service_flag;
	logic function_reset_link, serial_out_switch_select, serial_out_soft_disable, clock_output_pin;
	logic [15:0] reg_addr;
	logic [7:0]  reg_wdata, reg_rdata;
	logic [63:0] die_id;
	int          miscompares, n_checks, cnt;
	// field outputs packed in their register positions, so they compare against register values
	wire logic [7:0] ctl_pins = {pullup_pin, infrared_select, 1'b0, function_reset_link, 2'b00,
		setup_service_flag, transfer_dir};
	wire logic [7:0] mode_pins = {6'h00, serial_out_soft_disable, serial_out_switch_select};
	// bit 3 always written 0 by firmware; bit 5 stays 0 here, the wake pulse is tested by hand
	ucm_row_t rows [7] = '{'{16'hFFFC, 8'hD7, 8'hD7}, '{16'hFFFC, 8'h04, 8'h04},
		'{16'hFFFC, 8'h13, 8'h13}, '{16'hFFFB, 8'hFF, 8'h0F}, '{16'hFFFB, 8'h05, 8'h05},
		'{16'hFFEF, 8'hA5, DIE[63:56]}, '{16'hFFF0, 8'h5A, 8'h00}};

	ucm_far_model #(.DIE_ID_VALUE(DIE)) far (.core_clk(core_clk), .baud_clk_in(baud_clk_in), .die_id(die_id));
	ucm_regs uut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.bus_reset_signal(bus_reset_signal), .die_id(die_id), .baud_clk_in(baud_clk_in),
		.core_reset_b(core_reset_b), .pullup_pin(pullup_pin), .remote_wake_pulse(remote_wake_pulse),
		.infrared_select(infrared_select), .transfer_dir(transfer_dir), .setup_service_flag(setup_service_flag),
		.function_reset_link(function_reset_link), .serial_out_switch_select(serial_out_switch_select),
		.serial_out_soft_disable(serial_out_soft_disable), .clock_output_pin(clock_output_pin));

	// free-running core clock
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// each access first lets an edge pass, so a strobe is never dropped and raised in one time step,
	// then holds its request for exactly one rising edge
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		@(negedge core_clk);
		reg_wr_en = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(negedge core_clk);
		reg_rd_en = 1'b0;
		chk(reg_rdata, exp, "read data");
	endtask
	// counts level changes of the clock pin (sel 0) or high cycles of the wake pulse (sel 1)
	task automatic watch(input int n, input bit sel);
		cnt = 0;
		prev = clock_output_pin;
		repeat (n) begin
			@(negedge core_clk);
			if (sel) begin
				cnt += (remote_wake_pulse === 1'b1);
			end else begin
				cnt += (clock_output_pin !== prev);
			end
			prev = clock_output_pin;
		end
	endtask
	task automatic test_done;
		if (miscompares == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// main sequence: power-up reset, table of accesses, then the awkward cases
	initial begin
		{rst_b, reg_wr_en, reg_rd_en, bus_reset_signal, reg_addr, reg_wdata} = '0;
		miscompares = 0;
		n_checks = 0;
		repeat (16) @(negedge core_clk);
		rst_b = 1'b1;
		@(negedge core_clk);
		chk(ctl_pins, 8'h10, "control pins after reset");
		chk({7'h00, clock_output_pin}, 8'h00, "clock pin after reset");
		rd(ADDR_USB_CTL, USB_CTL_RESET);
		rd(ADDR_MODE_CFG, 8'h00);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
			if (rows[i].a == ADDR_USB_CTL) chk(ctl_pins, rows[i].e & 8'hD3, "control pins");
			if (rows[i].a == ADDR_MODE_CFG) chk(mode_pins, rows[i].e & 8'h03, "mode pins");
		end
		for (int i = 0; i < 8; i++) rd(ADDR_SERIAL_BASE + 16'(i), DIE[8*i +: 8]);
		// usb reset with the link set reaches the core reset but leaves both registers alone
		bus_reset_signal = 1'b1;
		@(negedge core_clk);
		chk({7'h00, core_reset_b}, 8'h00, "linked core reset");
		rd(ADDR_USB_CTL, 8'h13);
		rd(ADDR_MODE_CFG, 8'h05);
		wr(ADDR_USB_CTL, 8'h03);
		chk({7'h00, core_reset_b}, 8'h01, "unlinked core reset");
		bus_reset_signal = 1'b0;
		// wake request gives one pulse and clears itself; writing 0 gives none
		wr(ADDR_USB_CTL, 8'h23);
		watch(6, 1'b1);
		chk(8'(cnt), 8'h01, "wake pulse count");
		rd(ADDR_USB_CTL, 8'h03);
		wr(ADDR_USB_CTL, 8'h03);
		watch(6, 1'b1);
		chk(8'(cnt), 8'h00, "wake on zero write");
		// clock pin: baud source, fixed source, then disabled
		watch(20, 1'b0);
		chk(8'(cnt >= 9 && cnt <= 11), 8'h01, "baud clock on pin");
		wr(ADDR_MODE_CFG, 8'h0D);
		watch(12 * FIXED_HALF_CYCLES, 1'b0);
		chk(8'(cnt >= 11 && cnt <= 13), 8'h01, "fixed clock on pin");
		wr(ADDR_MODE_CFG, 8'h09);
		@(negedge core_clk);
		watch(12, 1'b0);
		chk({cnt[6:0], clock_output_pin}, 8'h00, "disabled clock pin");
		// power-up reset in mid-run restores control registers, serial byte untouched
		rst_b = 1'b0;
		repeat (2) @(negedge core_clk);
		rst_b = 1'b1;
		@(negedge core_clk);
		rd(ADDR_USB_CTL, USB_CTL_RESET);
		rd(ADDR_MODE_CFG, 8'h00);
		rd(ADDR_SERIAL_TOP, DIE[63:56]);
		test_done();
	end
endmodule

// ---- src/ucm_clock_out.sv ----
module ucm_clock_out import ucm_pkg::*; (
	input  wire logic core_clk,
	input  wire logic rst_b,
	input  wire logic enable,
	input  wire logic source_fixed,
	input  wire logic baud_clk_in,
	output logic      clk_pin
);

	logic [3:0] div_reg;
	logic [3:0] div_next;
	logic       fixed_reg;
	logic       fixed_next;
	logic       pin_reg;
	logic       pin_next;

	// free-running divider; at 25 MHz the fixed clock is only approximate
	always_comb begin
		div_next   = div_reg + 4'h1;
		fixed_next = fixed_reg;
		if (div_reg >= FIXED_HALF_LAST) begin
			div_next   = 4'h0;
			fixed_next = ~fixed_reg;
		end
		pin_next = 1'b0;                                  // [R11]
		if (enable) begin
			pin_next = source_fixed ? fixed_reg : baud_clk_in; // [R12]
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_reg   <= 4'h0;
			fixed_reg <= 1'b0;
			pin_reg   <= 1'b0;
		end else begin
			div_reg   <= div_next;
			fixed_reg <= fixed_next;
			pin_reg   <= pin_next;
		end
	end

	assign clk_pin = pin_reg;

	a_clk_pin_low: assert property (@(posedge core_clk) disable iff (!rst_b) // [R11]
		!enable |=> !clk_pin) else $error("clock pin not low while disabled");
	a_baud_select: assert property (@(posedge core_clk) disable iff (!rst_b) // [R12]
		enable && !source_fixed |=> clk_pin == $past(baud_clk_in)) else $error("baud clock not on pin");
	a_fixed_select: assert property (@(posedge core_clk) disable iff (!rst_b) // [R12]
		enable && source_fixed |=> clk_pin == $past(fixed_reg)) else $error("fixed clock not on pin");
	c_fixed_out: cover property (@(posedge core_clk) disable iff (!rst_b)
		enable && source_fixed ##1 clk_pin);

endmodule

// ---- src/ucm_pkg.sv ----
package ucm_pkg;

	// register addresses in the controller memory map
	localparam logic [15:0] ADDR_SERIAL_BASE = 16'hFFE8;
	localparam logic [15:0] ADDR_SERIAL_TOP  = 16'hFFEF;
	localparam logic [15:0] ADDR_MODE_CFG    = 16'hFFFB;
	localparam logic [15:0] ADDR_USB_CTL     = 16'hFFFC;

	// usb_port_control field positions
	localparam int unsigned CTL_DIR_BIT    = 0;
	localparam int unsigned CTL_SETUP_BIT  = 1;
	localparam int unsigned CTL_RSV2_BIT   = 2;
	localparam int unsigned CTL_RSV3_BIT   = 3;
	localparam int unsigned CTL_FRESET_BIT = 4;
	localparam int unsigned CTL_WAKE_BIT   = 5;
	localparam int unsigned CTL_IR_BIT     = 6;
	localparam int unsigned CTL_ATTACH_BIT = 7;

	// mode_configuration field positions
	localparam int unsigned MODE_SWSEL_BIT    = 0;
	localparam int unsigned MODE_SOFT_OFF_BIT = 1;
	localparam int unsigned MODE_CLKEN_BIT    = 2;
	localparam int unsigned MODE_CLKSRC_BIT   = 3;

	// reset values and writable masks
	localparam logic [7:0] USB_CTL_RESET  = 8'h10;
	localparam logic [7:0] MODE_CFG_RESET = 8'h00;
	localparam logic [7:0] MODE_CFG_MASK  = 8'h0F;

	// clock figures for the fixed clock output source
	localparam int unsigned CORE_CLK_HZ       = 25_000_000;
	localparam int unsigned FIXED_CLK_HZ      = 3_556_000;
	localparam int unsigned FIXED_HALF_CYCLES = (CORE_CLK_HZ / (2 * FIXED_CLK_HZ)) < 1 ? 1 :
		(CORE_CLK_HZ / (2 * FIXED_CLK_HZ));
	localparam logic [3:0]  FIXED_HALF_LAST   = 4'(FIXED_HALF_CYCLES - 1);

endpackage

// ---- src/ucm_regs.sv ----
// Overview of operation
// R1 - control registers cleared by power-up reset only
// R2 - control bit 0 holds transfer direction
// R3 - control bit 1 flags setup servicing
// R4 - reserved bits reset zero, write bit 3 zero
// R5 - bit 4 links function reset to core
// R6 - bit 5 write one emits wake pulse, self-clears
// R7 - bit 6 selects infrared codec over uart
// R8 - bit 7 enables pullup, port appears attached
// R9 - mode bit 0 selects serial buffer switching
// R10 - mode bit 1 soft-disables serial output buffer
// R11 - mode bit 2 gates clock pin, else low
// R12 - mode bit 3 picks fixed or baud clock
// R13 - eight read-only bytes expose 64-bit die id
// R14 - serial bytes unaffected by reset or writes
// R15 - core reset from power-up or linked bus reset
// R16 - pullup pin driven from attach bit
// R17 - serial bytes taken directly from die id input
// R18 - mode bits 7 to 4 read zero
module ucm_regs import ucm_pkg::*; (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic [15:0] reg_addr,
	input  wire logic        reg_wr_en,
	input  wire logic        reg_rd_en,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	input  wire logic        bus_reset_signal,
	input  wire logic [63:0] die_id,
	input  wire logic        baud_clk_in,
	output logic             core_reset_b,
	output logic             pullup_pin,
	output logic             remote_wake_pulse,
	output logic             infrared_select,
	output logic             transfer_dir,
	output logic             setup_service_flag,
	output logic             function_reset_link,
	output logic             serial_out_switch_select,
	output logic             serial_out_soft_disable,
	output logic             clock_output_pin
);

	logic [7:0] usb_ctl_reg;
	logic [7:0] usb_ctl_next;
	logic [7:0] mode_cfg_reg;
	logic [7:0] mode_cfg_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic       wake_reg;
	logic       wake_next;
	logic       wr_ctl;
	logic       wr_mode;
	logic [7:0] serial_byte [8];

	// true for any of the eight die id byte addresses
	function automatic logic is_serial(input logic [15:0] addr);
		return addr[15:3] == ADDR_SERIAL_BASE[15:3];
	endfunction

	// read mux; unmapped addresses answer zero
	function automatic logic [7:0] read_mux(input logic [15:0] addr, input logic [7:0] ctl,
		input logic [7:0] mode, input logic [7:0] ser);
		logic [7:0] val;
		val = 8'h00;
		if (addr == ADDR_USB_CTL) begin
			val = ctl;
		end else if (addr == ADDR_MODE_CFG) begin
			val = mode & MODE_CFG_MASK;                       // [R18]
		end else if (is_serial(addr)) begin
			val = ser;                                        // [R13] [R17]
		end
		return val;
	endfunction

	// die id cut into its eight bytes; byte n answers at the base address plus n
	for (genvar n = 0; n < 8; n++) begin : g_serial
		assign serial_byte[n] = die_id[8*n +: 8];             // [R13] [R17]
	end

	assign wr_ctl  = reg_wr_en && (reg_addr == ADDR_USB_CTL);
	assign wr_mode = reg_wr_en && (reg_addr == ADDR_MODE_CFG);

	// next values for the two control registers and the read port
	always_comb begin
		usb_ctl_next  = usb_ctl_reg;
		mode_cfg_next = mode_cfg_reg;
		// the wake request clears itself; a write in the same cycle wins, so no request is lost
		usb_ctl_next[CTL_WAKE_BIT] = 1'b0;                    // [R6]
		if (wr_ctl) begin
			usb_ctl_next = reg_wdata;                         // [R2] [R3] [R5] [R7] [R8]
		end
		if (wr_mode) begin
			mode_cfg_next = reg_wdata & MODE_CFG_MASK;        // [R9] [R10] [R11] [R12] [R18]
		end
		// serial byte writes fall through: no storage behind them
		wake_next  = usb_ctl_reg[CTL_WAKE_BIT];               // [R6]
		rdata_next = rdata_reg;
		if (reg_rd_en) begin
			rdata_next = read_mux(reg_addr, usb_ctl_reg, mode_cfg_reg, serial_byte[reg_addr[2:0]]); // [R14]
		end
	end

	// only the power-up reset clears these; the bus reset never reaches them
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			usb_ctl_reg  <= USB_CTL_RESET;                    // [R1] [R4] [R5] [R8]
			mode_cfg_reg <= MODE_CFG_RESET;                   // [R1]
			wake_reg     <= 1'b0;
			rdata_reg    <= 8'h00;
		end else begin
			usb_ctl_reg  <= usb_ctl_next;
			mode_cfg_reg <= mode_cfg_next;
			wake_reg     <= wake_next;
			rdata_reg    <= rdata_next;
		end
	end

	// rest of the chip resets on power-up or a linked function reset
	assign core_reset_b = rst_b && !(bus_reset_signal && usb_ctl_reg[CTL_FRESET_BIT]); // [R15] [R5]

	// outputs straight from the register bits
	assign reg_rdata                = rdata_reg;
	assign pullup_pin               = usb_ctl_reg[CTL_ATTACH_BIT];  // [R16] [R8]
	assign infrared_select          = usb_ctl_reg[CTL_IR_BIT];      // [R7]
	assign transfer_dir             = usb_ctl_reg[CTL_DIR_BIT];     // [R2]
	assign setup_service_flag       = usb_ctl_reg[CTL_SETUP_BIT];   // [R3]
	assign function_reset_link      = usb_ctl_reg[CTL_FRESET_BIT];  // [R5]
	assign remote_wake_pulse        = wake_reg;                     // [R6]
	assign serial_out_switch_select = mode_cfg_reg[MODE_SWSEL_BIT]; // [R9]
	assign serial_out_soft_disable  = mode_cfg_reg[MODE_SOFT_OFF_BIT]; // [R10]

	ucm_clock_out u_clock_out (
		.core_clk     (core_clk),
		.rst_b        (rst_b),
		.enable       (mode_cfg_reg[MODE_CLKEN_BIT]),
		.source_fixed (mode_cfg_reg[MODE_CLKSRC_BIT]),
		.baud_clk_in  (baud_clk_in),
		.clk_pin      (clock_output_pin)
	);

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	a_wake_pulse_timing: assert property ( // [R6]
		wr_ctl && reg_wdata[CTL_WAKE_BIT] |=> ##1 remote_wake_pulse) else $error("wake pulse missing");
	a_wake_self_clear: assert property ( // [R6]
		usb_ctl_reg[CTL_WAKE_BIT] && !wr_ctl |=> !usb_ctl_reg[CTL_WAKE_BIT] ##1 !remote_wake_pulse[*1])
		else $error("wake bit did not self clear");
	a_wake_zero_write: assert property ( // [R6]
		wr_ctl && !reg_wdata[CTL_WAKE_BIT] |=> ##1 !remote_wake_pulse) else $error("zero write made a pulse");
	a_ctl_write_fields: assert property ( // [R2] [R3] [R7] [R8]
		wr_ctl |=> pullup_pin == $past(reg_wdata[CTL_ATTACH_BIT]) &&
		infrared_select == $past(reg_wdata[CTL_IR_BIT]) &&
		transfer_dir == $past(reg_wdata[CTL_DIR_BIT]) &&
		setup_service_flag == $past(reg_wdata[CTL_SETUP_BIT])) else $error("control write not stored");
	a_bus_reset_keeps: assert property ( // [R1]
		bus_reset_signal && !reg_wr_en |=> $stable(mode_cfg_reg) && $stable(usb_ctl_reg[7:6]) &&
		$stable(usb_ctl_reg[4:0])) else $error("bus reset changed control state");
	a_core_reset_link: assert property ( // [R15] [R5]
		bus_reset_signal && function_reset_link |-> !core_reset_b) else $error("linked bus reset not passed");
	a_core_reset_unlink: assert property ( // [R15]
		!function_reset_link |-> core_reset_b) else $error("unlinked bus reset reached core");
	a_mode_reserved: assert property ( // [R18]
		wr_mode |=> mode_cfg_reg[7:4] == 4'h0 && mode_cfg_reg[3:0] == $past(reg_wdata[3:0]))
		else $error("mode write wrong");
	a_serial_top_read: assert property ( // [R13] [R17]
		reg_rd_en && reg_addr == ADDR_SERIAL_TOP |=> reg_rdata == $past(die_id[63:56]))
		else $error("top serial byte wrong");
	a_serial_no_write: assert property ( // [R14]
		reg_wr_en && is_serial(reg_addr) |=> $stable(mode_cfg_reg) && $stable(usb_ctl_reg[4:0]) &&
		$stable(usb_ctl_reg[7:6])) else $error("serial write disturbed state");
	a_unmapped_zero: assert property (
		reg_rd_en && reg_addr != ADDR_USB_CTL && reg_addr != ADDR_MODE_CFG && !is_serial(reg_addr)
		|=> reg_rdata == 8'h00) else $error("unmapped read not zero");

	// reset values, checked on the second low edge so the asynchronous clear has surely landed
	a_reset_values: assert property (disable iff (1'b0) // [R1] [R5] [R8]
		!rst_b && $past(!rst_b) |-> usb_ctl_reg == USB_CTL_RESET && mode_cfg_reg == MODE_CFG_RESET &&
		!remote_wake_pulse && reg_rdata == 8'h00) else $error("power-up reset values wrong");
	a_link_write: assert property ( // [R5] [R4]
		wr_ctl |=> function_reset_link == $past(reg_wdata[CTL_FRESET_BIT]) &&
		usb_ctl_reg[3:2] == $past(reg_wdata[3:2])) else $error("link or reserved bits not stored");
	a_mode_switch_bits: assert property ( // [R9] [R10]
		wr_mode |=> serial_out_switch_select == $past(reg_wdata[MODE_SWSEL_BIT]) &&
		serial_out_soft_disable == $past(reg_wdata[MODE_SOFT_OFF_BIT])) else $error("buffer switch bits not stored");
	a_serial_any_read: assert property ( // [R13] [R17]
		reg_rd_en && is_serial(reg_addr) |=> reg_rdata == 8'($past(die_id >> {reg_addr[2:0], 3'b000})))
		else $error("serial byte read wrong");
	a_mode_read_zero: assert property ( // [R18]
		reg_rd_en && reg_addr == ADDR_MODE_CFG |=> reg_rdata[7:4] == 4'h0)
		else $error("mode reserved bits read back");
	a_ctl_read_back: assert property ( // [R2] [R3]
		reg_rd_en && reg_addr == ADDR_USB_CTL |=> reg_rdata == $past(usb_ctl_reg))
		else $error("control read wrong");
	a_rdata_hold: assert property (
		!reg_rd_en |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	a_wake_needs_request: assert property ( // [R6]
		remote_wake_pulse |-> $past(usb_ctl_reg[CTL_WAKE_BIT]))
		else $error("wake pulse without request");
	a_wake_single: assert property ( // [R6]
		remote_wake_pulse && !$past(wr_ctl) |=> !remote_wake_pulse)
		else $error("wake pulse longer than one cycle");

	// settings only move on a write to their own register
	a_ctl_hold: assert property ( // [R1]
		!wr_ctl |=> $stable(usb_ctl_reg[4:0]) && $stable(usb_ctl_reg[7:6]))
		else $error("control bits moved without a write");
	a_mode_hold: assert property ( // [R1]
		!wr_mode |=> $stable(mode_cfg_reg))
		else $error("mode bits moved without a write");
	a_pullup_hold: assert property ( // [R16] [R8]
		!wr_ctl |=> $stable(pullup_pin))
		else $error("pullup moved without a write");

	c_wake_pulse: cover property (wr_ctl && reg_wdata[CTL_WAKE_BIT] ##2 remote_wake_pulse);
	c_serial_read: cover property (reg_rd_en && is_serial(reg_addr));
	c_core_reset: cover property (bus_reset_signal && function_reset_link);
	c_attach: cover property (wr_ctl ##1 pullup_pin);

endmodule
